/* File: design/temp_to_fan_cooling_map.sv */
// Purpose: Maps three temperature channels onto two fans by register.
// Assumes: Register port is driven by the serial management engine,
//          one request per cycle, synchronous to clock.
// Notes: Limit comparison and the speed curve live outside this block.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// (R01) Fan one select plus alarm event: alarm speed
// (R02) Fan one select, no event: automatic speed
// (R03) Fan one clear: channel ignored for fan one
// (R04) Fan two select bit works the same way
// (R05) Remote one to fan one, remote two fan two
// (R06) Local channel alone may drive both fans
// (R07) Remote one alone may drive both fans
// (R08) Remote two alone may drive both fans
// (R09) All three selected: fan runs at highest demand
// (R10) Unsupported map: fans use normal speed registers
// (R11) Bits two to seven read zero always
// (R12) Event needs fault action alarm enable bit
// (R13) Map decode is continuous, no extra action
module temp_to_fan_cooling_map
    import cooling_map_pkg::*;
#(
    parameter int SPEED_WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register access port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Per channel limit events, bit index is the channel
    input wire logic [CHANNEL_COUNT-1:0] high_exceeded,
    input wire logic [CHANNEL_COUNT-1:0] low_crossed,
    // Fault action registers of each channel, channel 0 in low byte
    input wire logic [CHANNEL_COUNT*8-1:0] fault_action,
    // Automatic control speed per channel, channel 0 in low slice
    input wire logic [CHANNEL_COUNT*SPEED_WIDTH-1:0] auto_speed,
    // Per fan speeds, fan one in low slice
    input wire logic [FAN_COUNT*SPEED_WIDTH-1:0] alarm_speed,
    input wire logic [FAN_COUNT*SPEED_WIDTH-1:0] normal_speed,
    // Fan results
    output logic [SPEED_WIDTH-1:0] fan_one_speed,
    output logic [SPEED_WIDTH-1:0] fan_two_speed,
    output fan_source_type fan_one_source,
    output fan_source_type fan_two_source,
    // Map status
    output logic map_supported
);

    // Only the two select bits of each cooling register are stored
    logic [SELECT_WIDTH-1:0] local_select;
    logic [SELECT_WIDTH-1:0] remote_one_select;
    logic [SELECT_WIDTH-1:0] remote_two_select;

    logic [CHANNEL_COUNT-1:0] demand;
    logic [CHANNEL_COUNT-1:0] fan_one_select;
    logic [CHANNEL_COUNT-1:0] fan_two_select;
    logic next_map_ok;
    logic [7:0] next_rdata;

    // Returns the stored select bits of a cooling register, or zeros
    function automatic logic [SELECT_WIDTH-1:0] select_of(
        input logic [7:0] addr,
        input logic [SELECT_WIDTH-1:0] loc,
        input logic [SELECT_WIDTH-1:0] rem1,
        input logic [SELECT_WIDTH-1:0] rem2
    );
        logic [SELECT_WIDTH-1:0] result;
        result = '0;
        case (addr)
            LOCAL_COOLING_OFFSET: result = loc;
            REMOTE_ONE_COOLING_OFFSET: result = rem1;
            REMOTE_TWO_COOLING_OFFSET: result = rem2;
            default: result = '0;
        endcase
        return result;
    endfunction

    // True when an address is one of the three cooling registers
    function automatic logic is_cooling(input logic [7:0] addr);
        return addr == LOCAL_COOLING_OFFSET ||
               addr == REMOTE_ONE_COOLING_OFFSET ||
               addr == REMOTE_TWO_COOLING_OFFSET;
    endfunction

    // Decides whether the select bits form one of the supported maps
    function automatic logic map_is_supported(
        input logic [SELECT_WIDTH-1:0] loc,
        input logic [SELECT_WIDTH-1:0] rem1,
        input logic [SELECT_WIDTH-1:0] rem2
    );
        logic split_map;
        logic local_only;
        logic remote_one_only;
        logic remote_two_only;
        logic all_three;
        split_map = (loc == '0) && !rem1[FAN_TWO_BIT] &&
                    !rem2[FAN_ONE_BIT];
        local_only = (rem1 == '0) && (rem2 == '0);
        remote_one_only = (loc == '0) && (rem2 == '0);
        remote_two_only = (loc == '0) && (rem1 == '0);
        // Per fan, the bit is either set in all three or in none
        all_three = ((loc & rem1 & rem2) == (loc | rem1 | rem2));
        return split_map || local_only || remote_one_only ||
               remote_two_only || all_three;
    endfunction

    // Cooling register writes; reserved bits are simply not stored
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            local_select <= COOLING_RESET[SELECT_WIDTH-1:0];
            remote_one_select <= COOLING_RESET[SELECT_WIDTH-1:0];
            remote_two_select <= COOLING_RESET[SELECT_WIDTH-1:0];
        end else if (reg_write) begin
            case (reg_addr)
                LOCAL_COOLING_OFFSET: begin
                    local_select <= reg_wdata[SELECT_WIDTH-1:0]; // (R11)
                end
                REMOTE_ONE_COOLING_OFFSET: begin
                    remote_one_select <= reg_wdata[SELECT_WIDTH-1:0];
                end
                REMOTE_TWO_COOLING_OFFSET: begin
                    remote_two_select <= reg_wdata[SELECT_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data: upper six bits are constant zero, unmapped reads zero
    always_comb begin
        next_rdata = READ_ZERO;
        if (is_cooling(reg_addr)) begin
            next_rdata[SELECT_WIDTH-1:0] = select_of(reg_addr, local_select,
                remote_one_select, remote_two_select); // (R11)
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= READ_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // A limit event asks for alarm speed only if that channel enables it
    generate
        for (genvar c = 0; c < CHANNEL_COUNT; c++) begin : g_demand
            assign demand[c] =
                (high_exceeded[c] && fault_action[c*8+ALARM_ON_HIGH_BIT]) ||
                (low_crossed[c] && fault_action[c*8+ALARM_ON_LOW_BIT]);
                // (R12)
        end
    endgenerate

    // Gather the per fan select vectors across channels
    assign fan_one_select[LOCAL_CHANNEL] = local_select[FAN_ONE_BIT];
    assign fan_one_select[REMOTE_ONE_CHANNEL] =
        remote_one_select[FAN_ONE_BIT];
    assign fan_one_select[REMOTE_TWO_CHANNEL] =
        remote_two_select[FAN_ONE_BIT];
    assign fan_two_select[LOCAL_CHANNEL] = local_select[FAN_TWO_BIT];
    assign fan_two_select[REMOTE_ONE_CHANNEL] =
        remote_one_select[FAN_TWO_BIT];
    assign fan_two_select[REMOTE_TWO_CHANNEL] =
        remote_two_select[FAN_TWO_BIT];

    // Decoded every cycle so a write takes effect with no other step
    assign next_map_ok = map_is_supported(local_select, remote_one_select,
        remote_two_select); // (R05) (R06) (R07) (R08) (R09) (R13)

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            map_supported <= 1'b0;
        end else begin
            map_supported <= next_map_ok; // (R10)
        end
    end

    // One selector per fan; the speed path uses the live decode so that
    // the speed and the status flag move on the same edge
    fan_speed_select #(
        .SPEED_WIDTH(SPEED_WIDTH),
        .CHANNELS(CHANNEL_COUNT)
    ) u_fan_one (
        .clock(clock),
        .rstn(rstn),
        .select(fan_one_select), // (R01) (R02) (R03)
        .demand(demand),
        .auto_speed(auto_speed),
        .alarm_speed(alarm_speed[0 +: SPEED_WIDTH]),
        .normal_speed(normal_speed[0 +: SPEED_WIDTH]),
        .map_ok(next_map_ok),
        .speed(fan_one_speed),
        .source(fan_one_source)
    );

    fan_speed_select #(
        .SPEED_WIDTH(SPEED_WIDTH),
        .CHANNELS(CHANNEL_COUNT)
    ) u_fan_two (
        .clock(clock),
        .rstn(rstn),
        .select(fan_two_select), // (R04)
        .demand(demand),
        .auto_speed(auto_speed),
        .alarm_speed(alarm_speed[SPEED_WIDTH +: SPEED_WIDTH]),
        .normal_speed(normal_speed[SPEED_WIDTH +: SPEED_WIDTH]),
        .map_ok(next_map_ok),
        .speed(fan_two_speed),
        .source(fan_two_source)
    );

endmodule
`default_nettype wire

/* File: design/cooling_map_pkg.sv */
// Purpose: Shared constants for the temperature to fan cooling map.
// Assumes: Register offsets are the device's own 8-bit command codes.
// Notes: Channel order is local, remote sensor one, remote sensor two.
package cooling_map_pkg;

    // Register map
    localparam logic [7:0] LOCAL_COOLING_OFFSET = 8'h48;
    localparam logic [7:0] REMOTE_ONE_COOLING_OFFSET = 8'h49;
    localparam logic [7:0] REMOTE_TWO_COOLING_OFFSET = 8'h4a;
    localparam logic [7:0] COOLING_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Cooling action register fields
    localparam int FAN_ONE_BIT = 0;
    localparam int FAN_TWO_BIT = 1;
    localparam int SELECT_WIDTH = 2;

    // Fault action register fields that ask for alarm speed
    localparam int ALARM_ON_HIGH_BIT = 1;
    localparam int ALARM_ON_LOW_BIT = 5;

    // Channel indices
    localparam int CHANNEL_COUNT = 3;
    localparam int LOCAL_CHANNEL = 0;
    localparam int REMOTE_ONE_CHANNEL = 1;
    localparam int REMOTE_TWO_CHANNEL = 2;

    // Fan count and speed reset value
    localparam int FAN_COUNT = 2;
    localparam logic [7:0] SPEED_RESET = 8'h00;

    // Source that a fan follows, reported for visibility
    typedef enum logic [1:0] {
        SOURCE_NORMAL,
        SOURCE_AUTO,
        SOURCE_ALARM
    } fan_source_type;

endpackage

/* File: design/fan_speed_select.sv */
// Purpose: Chooses one fan's speed from the channels that select it.
// Assumes: Speeds are unsigned duty values; larger means faster.
// Notes: Output speed and source are registered.
`timescale 1ns/1ns
`default_nettype none
module fan_speed_select
    import cooling_map_pkg::*;
#(
    parameter int SPEED_WIDTH = 8,
    parameter int CHANNELS = 3
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Per channel inputs
    input wire logic [CHANNELS-1:0] select,
    input wire logic [CHANNELS-1:0] demand,
    input wire logic [CHANNELS*SPEED_WIDTH-1:0] auto_speed,
    // Fan level inputs
    input wire logic [SPEED_WIDTH-1:0] alarm_speed,
    input wire logic [SPEED_WIDTH-1:0] normal_speed,
    input wire logic map_ok,
    // Result
    output logic [SPEED_WIDTH-1:0] speed,
    output fan_source_type source
);

    logic [SPEED_WIDTH-1:0] best;
    logic best_alarm;
    logic [SPEED_WIDTH-1:0] next_speed;
    fan_source_type next_source;

    // Highest demand among selecting channels; unselected ones are ignored
    always_comb begin
        logic [SPEED_WIDTH-1:0] want;
        want = '0;
        best = '0;
        best_alarm = 1'b0;
        for (int c = 0; c < CHANNELS; c++) begin
            want = demand[c] ? alarm_speed
                             : auto_speed[c*SPEED_WIDTH +: SPEED_WIDTH];
            if (select[c] && (want > best || (want == best && demand[c])))
            begin
                best = want; // (R01) (R02) (R03) (R04) (R09)
                best_alarm = demand[c];
            end
        end
    end

    // Unsupported map, or no channel on this fan, falls back to normal
    always_comb begin
        if (map_ok && (|select)) begin
            next_speed = best;
            next_source = best_alarm ? SOURCE_ALARM : SOURCE_AUTO;
        end else begin
            next_speed = normal_speed; // (R10)
            next_source = SOURCE_NORMAL;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            speed <= SPEED_RESET[SPEED_WIDTH-1:0];
            source <= SOURCE_NORMAL;
        end else begin
            speed <= next_speed; // (R13)
            source <= next_source;
        end
    end

endmodule
`default_nettype wire

/* File: verif/temp_to_fan_cooling_map_sva.sv */
// Purpose: Port level checks of the cooling map block.
// Assumes: Select bits are shadowed here from the register writes.
// Notes: Outputs lag the inputs that caused them by one edge.
`timescale 1ns/1ns
`default_nettype none
module temp_to_fan_cooling_map_sva
    import cooling_map_pkg::*;
#(
    parameter int SPEED_WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Channel inputs
    input wire logic [CHANNEL_COUNT-1:0] high_exceeded,
    input wire logic [CHANNEL_COUNT-1:0] low_crossed,
    input wire logic [CHANNEL_COUNT*8-1:0] fault_action,
    input wire logic [CHANNEL_COUNT*SPEED_WIDTH-1:0] auto_speed,
    input wire logic [FAN_COUNT*SPEED_WIDTH-1:0] alarm_speed,
    input wire logic [FAN_COUNT*SPEED_WIDTH-1:0] normal_speed,
    // Fan results
    input wire logic [SPEED_WIDTH-1:0] fan_one_speed,
    input wire logic [SPEED_WIDTH-1:0] fan_two_speed,
    input wire fan_source_type fan_one_source,
    input wire fan_source_type fan_two_source,
    input wire logic map_supported
);
    logic [5:0] sel;
    logic [7:0] rd_exp;
    logic map_ok;
    logic [2:0] dem;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sel <= 6'h00;
        end else if (reg_write) begin
            case (reg_addr)
                LOCAL_COOLING_OFFSET: sel[1:0] <= reg_wdata[1:0];
                REMOTE_ONE_COOLING_OFFSET: sel[3:2] <= reg_wdata[1:0];
                REMOTE_TWO_COOLING_OFFSET: sel[5:4] <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end
    always_comb begin
        rd_exp = 8'h00;
        case (reg_addr)
            LOCAL_COOLING_OFFSET: rd_exp = {6'h00, sel[1:0]};
            REMOTE_ONE_COOLING_OFFSET: rd_exp = {6'h00, sel[3:2]};
            REMOTE_TWO_COOLING_OFFSET: rd_exp = {6'h00, sel[5:4]};
            default: ;
        endcase
    end
    assign map_ok = (sel[1:0] == 2'h0 && !sel[3] && !sel[4])
        || sel[5:2] == 4'h0 || sel[3:0] == 4'h0
        || (sel[1:0] == 2'h0 && sel[5:4] == 2'h0)
        || (sel[1:0] == sel[3:2] && sel[3:2] == sel[5:4]);
    assign dem = (high_exceeded & {fault_action[17], fault_action[9],
        fault_action[1]}) | (low_crossed & {fault_action[21],
        fault_action[13], fault_action[5]});
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (reg_read |=> reg_rvalid
        && reg_rdata == $past(rd_exp)) else $error("bad read answer");
    a_rvalid_cause: assert property (!reg_read |=> !reg_rvalid)
        else $error("read valid without read");
    a_map_decode: assert property ($past(rstn)
        |-> map_supported == $past(map_ok)) else $error("map decode");
    a_unsupported_normal: assert property ($past(rstn) &&
        !map_supported |-> fan_one_source == SOURCE_NORMAL
        && fan_two_source == SOURCE_NORMAL
        && fan_one_speed == $past(normal_speed[SPEED_WIDTH-1:0])
        && fan_two_speed == $past(normal_speed[2*SPEED_WIDTH-1:SPEED_WIDTH]))
        else $error("unsupported map not at normal speed");
    a_alarm_one: assert property (fan_one_source == SOURCE_ALARM
        |-> fan_one_speed == $past(alarm_speed[SPEED_WIDTH-1:0])
        && $past(dem) != 3'h0) else $error("fan one alarm");
    a_alarm_two: assert property (fan_two_source == SOURCE_ALARM
        |-> fan_two_speed == $past(alarm_speed[2*SPEED_WIDTH-1:SPEED_WIDTH])
        && $past(dem) != 3'h0) else $error("fan two alarm");
    a_fan_one_select: assert property (
        fan_one_source != SOURCE_NORMAL
        |-> ($past(sel) & 6'h15) != 6'h00)
        else $error("fan one follows unselected channel");
    a_fan_two_select: assert property (
        fan_two_source != SOURCE_NORMAL
        |-> ($past(sel) & 6'h2a) != 6'h00)
        else $error("fan two follows unselected channel");
    c_unmapped: cover property (reg_read && reg_addr == 8'h4b);
    c_unsupported: cover property (!map_supported);
    c_alarm: cover property (fan_one_source == SOURCE_ALARM);
    c_auto: cover property (fan_two_source == SOURCE_AUTO);
endmodule
bind temp_to_fan_cooling_map temp_to_fan_cooling_map_sva #(
    .SPEED_WIDTH(SPEED_WIDTH)
) u_temp_to_fan_cooling_map_sva (.clock, .rstn, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .reg_rvalid, .high_exceeded,
    .low_crossed, .fault_action, .auto_speed, .alarm_speed, .normal_speed,
    .fan_one_speed, .fan_two_speed, .fan_one_source, .fan_two_source,
    .map_supported);
`default_nettype wire

/* File: verif/temp_to_fan_cooling_map_tb_top.sv */
// Purpose: Walks all 64 select maps with random channel inputs.
// Assumes: Default speed width of 8 bits.
// Notes: Upper write bits are random so reserved bits are exercised.
`timescale 1ns/1ns
`default_nettype none
module temp_to_fan_cooling_map_tb_top
    import cooling_map_pkg::*;
;
    logic clock, rstn, reg_write, reg_read, reg_rvalid, map_supported, ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fan_one_speed, fan_two_speed;
    logic [7:0] es, er;
    logic [2:0] high_exceeded, low_crossed;
    logic [23:0] fault_action, auto_speed;
    logic [15:0] alarm_speed, normal_speed;
    fan_source_type fan_one_source, fan_two_source;
    int err_count, checks_done;
    int sel [3];
    temp_to_fan_cooling_map u_temp_to_fan_cooling_map (.clock, .rstn,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .reg_rvalid, .high_exceeded, .low_crossed, .fault_action,
        .auto_speed, .alarm_speed, .normal_speed, .fan_one_speed,
        .fan_two_speed, .fan_one_source, .fan_two_source, .map_supported);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic cmp(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        cmp("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
        cmp("reg_rdata", e, reg_rdata);
    endtask
    // Highest demand wins; an equal alarm beats an automatic speed
    task automatic model(input int f, output logic [7:0] sp,
        output logic [7:0] sr);
        int best;
        int v;
        bit d;
        best = -1;
        sr = 8'(SOURCE_NORMAL);
        for (int c = 0; c < 3; c++) begin
            d = (high_exceeded[c] && fault_action[8*c+1])
                || (low_crossed[c] && fault_action[8*c+5]);
            v = d ? alarm_speed[8*f+:8] : auto_speed[8*c+:8];
            if (sel[c][f] && (v > best || (v == best && d))) begin
                best = v;
                sr = d ? 8'(SOURCE_ALARM) : 8'(SOURCE_AUTO);
            end
        end
        sp = 8'(best);
        if (!ok || best < 0) begin
            sp = normal_speed[8*f+:8];
            sr = 8'(SOURCE_NORMAL);
        end
    endtask
    initial begin
        #100000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        {rstn, reg_write, reg_read} = 3'b000;
        {reg_addr, reg_wdata, high_exceeded, low_crossed} = 22'h0;
        {fault_action, auto_speed, alarm_speed, normal_speed} = 80'h0;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'h3e7687d0));
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 128; i++) begin
            sel[0] = i % 4;
            sel[1] = (i / 4) % 4;
            sel[2] = (i / 16) % 4;
            for (int c = 0; c < 3; c++)
                wr(LOCAL_COOLING_OFFSET + 8'(c),
                    8'(($urandom % 64) * 4 + sel[c]));
            @(posedge clock);
            reg_write <= 1'b0;
            high_exceeded <= 3'($urandom);
            low_crossed <= 3'($urandom);
            fault_action <= 24'($urandom);
            auto_speed <= 24'($urandom);
            alarm_speed <= 16'($urandom);
            normal_speed <= 16'($urandom);
            repeat (2) @(posedge clock);
            #1;
            ok = (sel[0] == 0 && sel[1] < 2 && sel[2] % 2 == 0)
                || (sel[1] == 0 && sel[2] == 0) || (sel[0] == 0
                && (sel[1] == 0 || sel[2] == 0)) || (sel[0] == sel[1]
                && sel[1] == sel[2]);
            model(0, es, er);
            cmp("fan_one_speed", es, fan_one_speed);
            cmp("fan_one_source", er, 8'(fan_one_source));
            model(1, es, er);
            cmp("fan_two_speed", es, fan_two_speed);
            cmp("fan_two_source", er, 8'(fan_two_source));
            cmp("map_supported", 8'(ok), 8'(map_supported));
            rd(LOCAL_COOLING_OFFSET + 8'(i % 4),
                i % 4 == 3 ? 8'h00 : 8'(sel[i % 4]));
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
